// ===== logic/sfsp_pkg.sv
// Package: constants and state types for the serial flash SPI front end
package sfsp_pkg;
  localparam int SYS_CLK_PERIOD_PS = 4000;
  localparam int PUW_US            = 1000;
  localparam int PUW_CYCLES        = PUW_US * 1000000 / SYS_CLK_PERIOD_PS;

  localparam logic [7:0] OP_WREN    = 8'h06;
  localparam logic [7:0] OP_WRDI    = 8'h04;
  localparam logic [7:0] OP_RDSR    = 8'h05;
  localparam logic [7:0] OP_WRSR    = 8'h01;
  localparam logic [7:0] OP_READ    = 8'h03;
  localparam logic [7:0] OP_FAST    = 8'h0b;
  localparam logic [7:0] OP_DUAL    = 8'h3b;
  localparam logic [7:0] OP_PROG    = 8'h02;
  localparam logic [7:0] OP_SECT    = 8'h20;
  localparam logic [7:0] OP_BLOCK   = 8'hd8;
  localparam logic [7:0] OP_CHIP    = 8'hc7;
  localparam logic [7:0] OP_CHIP2   = 8'h60;
  localparam logic [7:0] OP_PDOWN   = 8'hb9;
  localparam logic [7:0] OP_RELEASE = 8'hab;

  localparam logic [5:0] CMD_BITS  = 6'h08;
  localparam logic [5:0] WSR_END   = 6'h10;
  localparam logic [5:0] ADDR_END  = 6'h20;
  localparam logic [5:0] FAST_END  = 6'h28;
  localparam logic [5:0] NBITS_SAT = 6'h30;
  localparam logic [5:0] NO_DATA   = 6'h3f;

  localparam int ST_BUSY  = 0;
  localparam int ST_WEL   = 1;
  localparam int ST_RANGE = 2;
  localparam int ST_DIR   = 5;
  localparam int ST_LOCK  = 7;
  localparam int LS_PD    = 8;
  localparam int LS_FRAME = 9;
  localparam int BLOCK_SHIFT = 16;

  typedef struct packed {
    logic [7:0]  shin;
    logic [5:0]  nbits;
    logic [2:0]  phase;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [7:0]  wsr_data;
    logic [23:0] rd_addr;
  } sfsp_rx_s;

  typedef struct packed {
    logic [7:0] txb;
    logic       do_bit;
    logic       dio_bit;
  } sfsp_tx_s;

  typedef struct packed {
    logic [9:0] s1;
    logic [9:0] s2;
  } sfsp_lsync_s;

  typedef struct packed {
    logic [2:0]  cs_sync;
    logic [1:0]  wp_sync;
    logic        armed;
    logic        frame_ok;
    logic [31:0] puw_cnt;
    logic        inhibit;
    logic        write_enable_latch;
    logic        busy;
    logic        lock;
    logic        dir;
    logic [2:0]  range;
    logic        pd;
    logic        start;
    logic [7:0]  code;
    logic [23:0] op_addr;
  } sfsp_sys_s;
endpackage

// ===== logic/sfsp_front_end.sv
// Serial flash SPI front end: link shifter, hold, and write-protection gating
`timescale 1ns/1ps
module sfsp_front_end
  import sfsp_pkg::*;
#(
  parameter int unsigned ARRAY_ADDR_BITS = 20,
  parameter int unsigned PUW_CNT         = PUW_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        spi_clk,
  input  wire logic        cs_n,
  input  wire logic        hold_n,
  input  wire logic        wp_n,
  input  wire logic        dio_in,
  output logic             dio_out,
  output logic             dio_oe_n,
  output logic             do_out,
  output logic             do_oe_n,
  output logic [23:0]      array_rd_addr,
  input  wire logic [7:0]  array_rd_data,
  output logic             op_start,
  output logic [7:0]       op_code,
  output logic [23:0]      op_addr,
  input  wire logic        op_done,
  output logic [7:0]       status_byte,
  output logic             power_down
);
  localparam int BLK_BITS = ARRAY_ADDR_BITS - BLOCK_SHIFT;
  localparam logic [7:0] BLK_MASK = 8'((1 << BLK_BITS) - 1);

  sfsp_rx_s    rx_reg;
  sfsp_rx_s    rx_next;
  sfsp_tx_s    tx_reg;
  sfsp_tx_s    tx_next;
  sfsp_lsync_s ls_reg;
  sfsp_lsync_s ls_next;
  sfsp_sys_s   s_reg;
  sfsp_sys_s   s_next;
  logic        frame_open_reg;
  logic        pause_reg;
  logic        oe_kill;
  logic        do_oe_next;
  logic        dio_oe_next;
  logic        fresh;
  logic [5:0]  cnt;
  logic [2:0]  ph;
  logic        in_data;
  logic        byte_end;
  logic        rd_ok;
  logic        dual;
  logic        load;
  logic        emit;
  logic [7:0]  cur_byte;
  logic        cs_rise;
  logic        cs_fall;
  logic        launch;
  logic        wr_ok;

  function automatic logic [5:0] data_start(input logic [7:0] op);
    case (op)
      OP_READ:          data_start = ADDR_END;
      OP_FAST, OP_DUAL: data_start = FAST_END;
      OP_RDSR:          data_start = CMD_BITS;
      default:          data_start = NO_DATA;
    endcase
  endfunction

  // Block-granular range: 2^(range-1) blocks from the chosen end
  function automatic logic addr_protected(input logic [23:0] a, input logic [2:0] rng, input logic dir);
    logic [7:0] blk;
    logic [2:0] n;
    blk = a[23:BLOCK_SHIFT] & BLK_MASK;
    n   = rng - 3'd1;
    if (rng == 3'd0) begin
      addr_protected = 1'b0;
    end else if (32'(n) >= BLK_BITS) begin
      addr_protected = 1'b1;
    end else if (dir) begin
      addr_protected = (blk >> n) == 8'h00;
    end else begin
      addr_protected = (blk >> n) == (BLK_MASK >> n);
    end
  endfunction

  // ---------------- Link domain ----------------

  // Chip select high drops the half-received instruction
  always_ff @(posedge spi_clk or posedge cs_n or posedge rst) begin
    if (rst) begin
      frame_open_reg <= 1'b0;
    end else if (cs_n) begin
      frame_open_reg <= 1'b0;
    end else if (hold_n) begin
      frame_open_reg <= 1'b1;
    end
  end

  // Hold level at a rising edge governs the falling edge after it,
  // so a hold taken while the clock is high still lets that edge shift
  always_ff @(posedge spi_clk or posedge rst) begin
    if (rst) begin
      pause_reg <= 1'b0;
    end else begin
      pause_reg <= !hold_n;
    end
  end

  always_comb begin
    rx_next  = rx_reg;
    fresh    = !frame_open_reg;
    cnt      = fresh ? 6'h00 : rx_reg.nbits;
    ph       = fresh ? 3'h0 : rx_reg.phase;
    in_data  = cnt >= data_start(rx_reg.opcode);
    byte_end = (rx_reg.opcode == OP_DUAL) ? (ph[1:0] == 2'h3) : (ph == 3'h7);
    // Hold as it stands at the rising edge decides whether the edge counts
    if (hold_n) begin
      rx_next.shin  = {rx_reg.shin[6:0], dio_in};
      rx_next.nbits = (cnt == NBITS_SAT) ? cnt : cnt + 6'h01;
      rx_next.phase = ph + 3'h1;
      if (rx_next.nbits == CMD_BITS) begin
        rx_next.opcode = {rx_reg.shin[6:0], dio_in};
      end
      if (rx_next.nbits > CMD_BITS && rx_next.nbits <= ADDR_END) begin
        rx_next.addr = {rx_reg.addr[22:0], dio_in};
      end
      if (rx_next.nbits == WSR_END) begin
        rx_next.wsr_data = {rx_reg.shin[6:0], dio_in};
      end
      if (rx_next.nbits == ADDR_END) begin
        rx_next.rd_addr = {rx_reg.addr[22:0], dio_in};
      end else if (in_data && byte_end && cnt >= CMD_BITS) begin
        rx_next.rd_addr = rx_reg.rd_addr + 24'h000001;
      end
    end
  end

  // Sampling on the rising edge alone serves both idle clock levels
  always_ff @(posedge spi_clk or posedge rst) begin
    if (rst) begin
      rx_reg <= '0;
    end else begin
      rx_reg <= rx_next;
    end
  end

  always_comb begin
    ls_next    = ls_reg;
    ls_next.s1 = {s_reg.frame_ok, s_reg.pd, status_byte};
    ls_next.s2 = ls_reg.s1;
  end

  always_ff @(posedge spi_clk or posedge rst) begin
    if (rst) begin
      ls_reg <= '0;
    end else begin
      ls_reg <= ls_next;
    end
  end

  always_comb begin
    tx_next  = tx_reg;
    dual     = rx_reg.opcode == OP_DUAL;
    rd_ok    = ls_reg.s2[LS_FRAME] && !ls_reg.s2[LS_PD] &&
               (!ls_reg.s2[ST_BUSY] || rx_reg.opcode == OP_RDSR);
    emit     = frame_open_reg && rd_ok && rx_reg.nbits >= data_start(rx_reg.opcode);
    load     = dual ? (rx_reg.phase[1:0] == 2'h0) : (rx_reg.phase == 3'h0);
    cur_byte = load ? ((rx_reg.opcode == OP_RDSR) ? ls_reg.s2[7:0] : array_rd_data) : tx_reg.txb;
    if (emit && !pause_reg) begin
      tx_next.do_bit = cur_byte[7];
      if (dual) begin
        tx_next.dio_bit = cur_byte[6];
        tx_next.txb     = {cur_byte[5:0], 2'b00};
      end else begin
        tx_next.txb     = {cur_byte[6:0], 1'b0};
      end
    end
    do_oe_next  = !(emit && hold_n);
    dio_oe_next = !(emit && hold_n && dual);
  end

  always_ff @(negedge spi_clk or posedge rst) begin
    if (rst) begin
      tx_reg <= '0;
    end else begin
      tx_reg <= tx_next;
    end
  end

  // Enables float at once; data comes back only on a falling edge
  assign oe_kill = rst | cs_n | !hold_n;

  always_ff @(negedge spi_clk or posedge oe_kill) begin
    if (oe_kill) begin
      do_oe_n  <= 1'b1;
      dio_oe_n <= 1'b1;
    end else begin
      do_oe_n  <= do_oe_next;
      dio_oe_n <= dio_oe_next;
    end
  end

  assign do_out        = tx_reg.do_bit;
  assign dio_out       = tx_reg.dio_bit;
  assign array_rd_addr = rx_reg.rd_addr;

  // ---------------- System domain ----------------

  // Link fields are read only after chip select has settled high
  always_comb begin
    s_next         = s_reg;
    s_next.start   = 1'b0;
    launch         = 1'b0;
    s_next.cs_sync = {s_reg.cs_sync[1:0], cs_n};
    s_next.wp_sync = {s_reg.wp_sync[0], wp_n};
    cs_rise        = s_reg.cs_sync[1] && !s_reg.cs_sync[2];
    cs_fall        = !s_reg.cs_sync[1] && s_reg.cs_sync[2];
    wr_ok          = s_reg.write_enable_latch && !s_reg.inhibit;
    if (s_reg.puw_cnt != 32'h0) begin
      s_next.puw_cnt = s_reg.puw_cnt - 32'h1;
    end
    s_next.inhibit = s_reg.puw_cnt != 32'h0;
    if (s_reg.cs_sync[1]) begin
      s_next.armed = 1'b1;
    end
    if (cs_fall) begin
      s_next.frame_ok = s_reg.armed;
    end
    if (s_reg.busy && op_done) begin
      s_next.busy = 1'b0;
      s_next.write_enable_latch  = 1'b0;
    end
    if (cs_rise) begin
      s_next.frame_ok = 1'b0;
      if (s_reg.frame_ok && !s_reg.busy) begin
        if (s_reg.pd) begin
          if (rx_reg.opcode == OP_RELEASE && rx_reg.nbits == CMD_BITS) begin
            s_next.pd = 1'b0;
          end
        end else begin
          case (rx_reg.opcode)
            OP_WREN: begin
              if (rx_reg.nbits == CMD_BITS && !s_reg.inhibit) begin
                s_next.write_enable_latch = 1'b1;
              end
            end
            OP_WRDI: begin
              if (rx_reg.nbits == CMD_BITS) begin
                s_next.write_enable_latch = 1'b0;
              end
            end
            OP_WRSR: begin
              if (rx_reg.nbits == WSR_END && wr_ok && !(s_reg.lock && !s_reg.wp_sync[1])) begin
                s_next.lock  = rx_reg.wsr_data[ST_LOCK];
                s_next.dir   = rx_reg.wsr_data[ST_DIR];
                s_next.range = rx_reg.wsr_data[ST_RANGE +: 3];
                launch       = 1'b1;
              end
            end
            OP_PROG: begin
              if (rx_reg.nbits >= FAST_END && rx_reg.phase == 3'h0 && wr_ok &&
                  !addr_protected(rx_reg.addr, s_reg.range, s_reg.dir)) begin
                launch = 1'b1;
              end
            end
            OP_SECT, OP_BLOCK: begin
              if (rx_reg.nbits == ADDR_END && wr_ok &&
                  !addr_protected(rx_reg.addr, s_reg.range, s_reg.dir)) begin
                launch = 1'b1;
              end
            end
            OP_CHIP, OP_CHIP2: begin
              if (rx_reg.nbits == CMD_BITS && wr_ok && s_reg.range == 3'h0) begin
                launch = 1'b1;
              end
            end
            OP_PDOWN: begin
              if (rx_reg.nbits == CMD_BITS) begin
                s_next.pd = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
    // Engine runs on with chip select high until it reports done
    if (launch) begin
      s_next.start   = 1'b1;
      s_next.busy    = 1'b1;
      s_next.code    = rx_reg.opcode;
      s_next.op_addr = rx_reg.addr;
    end
  end

  // Power-on reset: nothing recognised, latch cleared, inhibit timer loaded
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_reg         <= '0;
      s_reg.cs_sync <= 3'b000;
      s_reg.puw_cnt <= PUW_CNT;
      s_reg.inhibit <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign op_start    = s_reg.start;
  assign op_code     = s_reg.code;
  assign op_addr     = s_reg.op_addr;
  assign power_down  = s_reg.pd;
  assign status_byte = {s_reg.lock, 1'b0, s_reg.dir, s_reg.range, s_reg.write_enable_latch, s_reg.busy};

  // ---------------- Checks ----------------

  sequence s_cs_rise;
    s_reg.cs_sync[1] && !s_reg.cs_sync[2];
  endsequence

  sequence s_wren_done;
    s_cs_rise ##0 (s_reg.frame_ok && !s_reg.busy && !s_reg.pd && !s_reg.inhibit &&
                   rx_reg.opcode == OP_WREN && rx_reg.nbits == CMD_BITS);
  endsequence

  property p_wren_sets;
    @(posedge sys_clk) disable iff (rst) s_wren_done |=> s_reg.write_enable_latch;
  endproperty
  a_wren_sets: assert property (p_wren_sets) else $error("write enable did not set latch");

  property p_done_clears;
    @(posedge sys_clk) disable iff (rst) (s_reg.busy && op_done) |=> (!s_reg.write_enable_latch && !s_reg.busy);
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("completion left latch or busy set");

  property p_start_needs_wel;
    @(posedge sys_clk) disable iff (rst) $rose(op_start) |-> ($past(s_reg.write_enable_latch) && !$past(s_reg.inhibit));
  endproperty
  a_start_needs_wel: assert property (p_start_needs_wel) else $error("operation started without latch");

  property p_inhibit_no_wel;
    @(posedge sys_clk) disable iff (rst) s_reg.inhibit |-> !s_reg.write_enable_latch;
  endproperty
  a_inhibit_no_wel: assert property (p_inhibit_no_wel) else $error("latch set during inhibit delay");

  property p_busy_holds;
    @(posedge sys_clk) disable iff (rst) op_start |-> s_reg.busy ##1 (s_reg.busy || $past(op_done));
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("busy not held after start");

  property p_pd_blocks;
    @(posedge sys_clk) disable iff (rst) $past(s_reg.pd) |-> !$rose(s_reg.write_enable_latch) && !op_start;
  endproperty
  a_pd_blocks: assert property (p_pd_blocks) else $error("instruction obeyed in power-down");

  property p_lock_blocks;
    @(posedge sys_clk) disable iff (rst)
      (op_start && op_code == OP_WRSR) |-> !($past(s_reg.lock) && !$past(s_reg.wp_sync[1]));
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("locked status register written");

  property p_cs_floats;
    @(posedge sys_clk) disable iff (rst) s_reg.cs_sync[1] |-> (do_oe_n && dio_oe_n);
  endproperty
  a_cs_floats: assert property (p_cs_floats) else $error("output driven while deselected");

  property p_dio_dual_only;
    @(negedge spi_clk) disable iff (rst) !dio_oe_n |-> rx_reg.opcode == OP_DUAL;
  endproperty
  a_dio_dual_only: assert property (p_dio_dual_only) else $error("data pin driven outside dual read");

  property p_pause_freezes;
    @(posedge spi_clk) disable iff (rst) !hold_n |=> rx_reg.nbits == $past(rx_reg.nbits);
  endproperty
  a_pause_freezes: assert property (p_pause_freezes) else $error("bit count moved during pause");
endmodule

// ===== test/sfsp_host_model.sv
// SPI host model that drives the link side of the flash front end
`timescale 1ns/1ps
module sfsp_host_model (
  output logic      spi_clk,
  output logic      cs_n,
  output logic      hold_n,
  output logic      host_dio,
  input  wire logic mode3,
  input  wire logic dio_wire,
  input  wire logic do_out,
  input  wire logic do_oe_n,
  input  wire logic dio_oe_n
);
  initial begin
    spi_clk  = 1'b0;
    // Starts low: chip select does not track the supply here
    cs_n     = 1'b0;
    hold_n   = 1'b1;
    host_dio = 1'b0;
  end

  task automatic xfer(input logic [39:0] tx, input int ntx, input int nrx, input logic dual,
                      input int hold_at, output logic [7:0] rx, output logic drv, output logic ddrv);
    drv = 1'b0;
    ddrv = 1'b0;
    rx = 8'h00;
    spi_clk = mode3;
    #20;
    cs_n = 1'b0;
    #40;
    for (int i = 0; i < ntx + nrx; i++) begin
      spi_clk = 1'b0;
      // Line not carrying a command bit toggles so no stale level is seen
      host_dio = (i < ntx) ? tx[39 - i] : ~host_dio;
      #62.5;
      spi_clk = 1'b1;
      if (i >= ntx) begin
        // A floating do_out reads back inverted so a missing drive shows up; a floating data line reads back host_dio
        rx = dual ? {rx[5:0], (do_oe_n ? ~do_out : do_out), dio_wire} :
                    {rx[6:0], (do_oe_n ? ~do_out : do_out)};
      end
      if (do_oe_n === 1'b0) begin
        drv = 1'b1;
      end
      if (dio_oe_n === 1'b0) begin
        ddrv = 1'b1;
      end
      if (i == hold_at) begin
        // Chip select stays low through the pause; garbage clocks meanwhile
        // Hold moves while the clock is high, clear of any clock edge
        #10 hold_n = 1'b0;
        #21 spi_clk = 1'b0;
        host_dio = ~host_dio;
        #31 spi_clk = 1'b1;
        #31 spi_clk = 1'b0;
        host_dio = ~host_dio;
        #31 spi_clk = 1'b1;
        #10 hold_n = 1'b1;
      end
      #62.5;
    end
    spi_clk = mode3;
    #20;
    cs_n = 1'b1;
    host_dio = ~host_dio;
    #100;
  endtask
endmodule

// ===== test/tb.sv
// Self-checking bench for the serial flash SPI front end
`timescale 1ns/1ps
module tb;
  import sfsp_pkg::*;
  typedef struct {logic [39:0] tx; int n; logic wp; logic st; logic [7:0] sb;} sfsp_row_s;

  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        wp_n = 1'b1;
  logic        op_done = 1'b0;
  logic        mode3 = 1'b0;
  logic        spi_clk, cs_n, hold_n, host_dio, dio_wire;
  logic        dio_out, dio_oe_n, do_out, do_oe_n, op_start, power_down;
  logic [23:0] array_rd_addr, op_addr;
  logic [7:0]  array_rd_data, op_code, status_byte, last_code, r;
  logic        dv, ddv;
  int          failures = 0;
  int          check_count = 0;
  int          starts = 0;
  int          n0;
  sfsp_row_s   rows [18] = '{
    '{40'h0600000000, 8, 1'b1, 1'b0, 8'h02},
    '{40'h0400000000, 8, 1'b1, 1'b0, 8'h00},
    '{40'h0600000000, 7, 1'b1, 1'b0, 8'h00},
    '{40'h200f000000, 32, 1'b1, 1'b0, 8'h00},
    '{40'h0600000000, 8, 1'b1, 1'b0, 8'h02},
    '{40'h01a4000000, 16, 1'b1, 1'b1, 8'ha7},
    '{40'h0600000000, 8, 1'b1, 1'b0, 8'ha6},
    '{40'h2000010000, 32, 1'b1, 1'b0, 8'ha6},
    '{40'h200f000000, 32, 1'b1, 1'b1, 8'ha7},
    '{40'h0600000000, 8, 1'b1, 1'b0, 8'ha6},
    '{40'h0100000000, 16, 1'b0, 1'b0, 8'ha6},
    '{40'h0100000000, 16, 1'b1, 1'b1, 8'h03},
    '{40'h0600000000, 8, 1'b1, 1'b0, 8'h02},
    '{40'h020f0000aa, 40, 1'b1, 1'b1, 8'h03},
    '{40'h0600000000, 8, 1'b1, 1'b0, 8'h02},
    '{40'hd808000000, 32, 1'b1, 1'b1, 8'h03},
    '{40'h0600000000, 8, 1'b1, 1'b0, 8'h02},
    '{40'hc700000000, 8, 1'b1, 1'b1, 8'h03}
  };

  // Released data line reads back the device only while it drives
  assign dio_wire = dio_oe_n ? host_dio : dio_out;
  assign array_rd_data = array_rd_addr[7:0] ^ 8'h5a;

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (op_start === 1'b1) begin
      starts <= starts + 1;
      last_code <= op_code;
    end
  end

  sfsp_front_end #(.PUW_CNT(2000)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .spi_clk(spi_clk), .cs_n(cs_n), .hold_n(hold_n), .wp_n(wp_n),
    .dio_in(dio_wire), .dio_out(dio_out), .dio_oe_n(dio_oe_n), .do_out(do_out), .do_oe_n(do_oe_n),
    .array_rd_addr(array_rd_addr), .array_rd_data(array_rd_data), .op_start(op_start),
    .op_code(op_code), .op_addr(op_addr), .op_done(op_done), .status_byte(status_byte),
    .power_down(power_down)
  );

  sfsp_host_model i_host (
    .spi_clk(spi_clk), .cs_n(cs_n), .hold_n(hold_n), .host_dio(host_dio), .mode3(mode3),
    .dio_wire(dio_wire), .do_out(do_out), .do_oe_n(do_oe_n), .dio_oe_n(dio_oe_n)
  );

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic frame(input logic [39:0] tx, input int ntx, input int nrx, input logic dual, input int hold_at);
    i_host.xfer(tx, ntx, nrx, dual, hold_at, r, dv, ddv);
  endtask

  // Commands land a few system cycles after chip select rises
  task automatic settle();
    repeat (12) @(negedge sys_clk);
  endtask

  task automatic report_and_stop();
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #300000;
    failures++;
    report_and_stop();
  end

  initial begin
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    chk(status_byte, 40'h00);
    chk({do_oe_n, dio_oe_n, op_start, power_down}, 40'hc);
    frame(40'h0500000000, 8, 8, 1'b0, -1);
    chk(dv, 40'h0);
    frame(40'h0600000000, 8, 0, 1'b0, -1);
    settle();
    chk(status_byte, 40'h00);
    repeat (2000) @(negedge sys_clk);
    foreach (rows[k]) begin
      wp_n = rows[k].wp;
      n0 = starts;
      frame(rows[k].tx, rows[k].n, 0, 1'b0, -1);
      settle();
      chk(status_byte, rows[k].sb);
      chk(40'(starts - n0), rows[k].st);
      if (rows[k].st) begin
        chk(last_code, rows[k].tx[39:32]);
        op_done = 1'b1;
        @(negedge sys_clk);
        op_done = 1'b0;
        settle();
        chk(status_byte, rows[k].sb & 8'hfc);
      end
    end
    // While busy only the status read is obeyed
    frame(40'h0600000000, 8, 0, 1'b0, -1);
    frame(40'h200f000000, 32, 0, 1'b0, -1);
    chk(op_addr, 40'h0f0000);
    frame(40'h0400000000, 8, 0, 1'b0, -1);
    frame(40'h0500000000, 8, 8, 1'b0, -1);
    chk(r, 40'h03);
    settle();
    chk(status_byte, 40'h03);
    op_done = 1'b1;
    @(negedge sys_clk);
    op_done = 1'b0;
    settle();
    chk(status_byte, 40'h00);
    frame(40'h0300001200, 32, 8, 1'b0, -1);
    chk(r, 40'h48);
    chk({dv, ddv}, 40'h2);
    chk(do_oe_n, 40'h1);
    mode3 = 1'b1;
    frame(40'h0b00003400, 40, 8, 1'b0, -1);
    chk(r, 40'h6e);
    mode3 = 1'b0;
    frame(40'h3b00005600, 40, 4, 1'b1, -1);
    chk(r, 40'h0c);
    chk(ddv, 40'h1);
    frame(40'h0300007700, 32, 8, 1'b0, 10);
    chk(r, 40'h2d);
    frame(40'hb900000000, 8, 0, 1'b0, -1);
    settle();
    chk(power_down, 40'h1);
    frame(40'h0600000000, 8, 0, 1'b0, -1);
    settle();
    chk(status_byte, 40'h00);
    frame(40'h0500000000, 8, 8, 1'b0, -1);
    chk(dv, 40'h0);
    frame(40'hab00000000, 8, 0, 1'b0, -1);
    settle();
    chk(power_down, 40'h0);
    report_and_stop();
  end
endmodule
